/* File: logic/mrd_pkg.sv */
// Constants, tables and state type for the module register space decoder
package mrd_pkg;
  // Bus widths
  localparam int MRD_ADDR_W = 24;
  localparam int MRD_DATA_W = 16;
  // Register block placement: A[23] = map bit, A[22:20] = 111
  localparam logic [2:0] MRD_BLK_TOP3 = 3'h7;
  // Remaining fixed high bits A[19:12] of the block
  localparam logic [7:0] MRD_BLK_MID = 8'hFF;
  // Largest number of module sub-blocks the tables describe
  localparam int MRD_NUM_SLOT = 4;
  // Sub-block offsets inside the 4-Kbyte block
  localparam logic [11:0] MRD_SLOT_BASE [MRD_NUM_SLOT] =
    '{12'h000, 12'h040, 12'h200, 12'h400};
  // Sub-block sizes as log2 of bytes
  localparam int MRD_SLOT_SIZE_LOG2 [MRD_NUM_SLOT] = '{6, 6, 9, 8};
  // Implemented bytes at the start of each sub-block
  localparam int MRD_SLOT_IMPL [MRD_NUM_SLOT] = '{32, 48, 256, 64};
  // Reserved bytes that follow the implemented ones
  localparam int MRD_SLOT_RESV [MRD_NUM_SLOT] = '{16, 8, 128, 64};
  // Implemented bit positions of each module's registers
  localparam logic [15:0] MRD_SLOT_MASK [MRD_NUM_SLOT] =
    '{16'hFFFF, 16'h00FF, 16'h0FFF, 16'h807F};
  // Memory arrays (RAM, ROM, flash) and their control blocks
  localparam int MRD_NUM_ARR = 3;
  localparam logic [11:0] MRD_ARR_CTRL [MRD_NUM_ARR] =
    '{12'h700, 12'h740, 12'h780};
  // Register offsets inside an array control block
  localparam logic [3:0] MRD_ARR_EN_OFS = 4'h0;
  localparam logic [3:0] MRD_ARR_BASE_OFS = 4'h2;
  // Field positions
  localparam int MRD_ARR_EN_BIT = 0;
  localparam int MRD_ARR_BASE_W = 8;
  // Reset values: arrays off and based at zero
  localparam logic MRD_ARR_EN_RST = 1'b0;
  localparam logic [7:0] MRD_ARR_BASE_RST = 8'h00;
  localparam logic [15:0] MRD_RD_DATA_RST = 16'h0000;

  // All state of the decoder
  typedef struct packed {
    logic [MRD_NUM_ARR-1:0] arr_en;
    logic [MRD_NUM_ARR*MRD_ARR_BASE_W-1:0] arr_base;
    logic rd_valid;
    logic [MRD_DATA_W-1:0] rd_data;
  } mrd_state_t;

  localparam mrd_state_t MRD_STATE_RST = '{
    arr_en: {MRD_NUM_ARR{MRD_ARR_EN_RST}},
    arr_base: {MRD_NUM_ARR{MRD_ARR_BASE_RST}},
    rd_valid: 1'b0,
    rd_data: MRD_RD_DATA_RST};
endpackage

/* File: logic/mrd_slot.sv */
// One module sub-block: range, implemented and reserved decode
`timescale 1ns/1ps
module mrd_slot #(
  parameter logic [11:0] BASE = 12'h000,
  parameter int SIZE_LOG2 = 6,
  parameter int IMPL_BYTES = 16,
  parameter int RESV_BYTES = 16
) (
  input wire logic [11:0] addr_lo,
  input wire logic in_block,
  input wire logic user_mode,
  input wire logic supervisor_only_bit_only,
  output logic claim,
  output logic resv_hit
);
  // Offset of the access inside this sub-block
  logic [11:0] ofs;
  // Access falls in this sub-block's window
  logic in_range;
  // Access blocked by supervisor-only protection
  logic blocked;

  // Refuse tables the decode cannot serve
  if (SIZE_LOG2 < 1 || SIZE_LOG2 > 11 ||
      IMPL_BYTES + RESV_BYTES > (1 << SIZE_LOG2)) begin : g_chk
    $error("mrd_slot: sub-block table out of range");
  end

  assign ofs = addr_lo - BASE;
  assign in_range = in_block &&
    (addr_lo[11:SIZE_LOG2] == BASE[11:SIZE_LOG2]);
  assign blocked = user_mode && supervisor_only_bit_only;
  // holes beyond reserved space stay unclaimed
  assign claim = in_range && !blocked &&
    (ofs < 12'(IMPL_BYTES + RESV_BYTES));
  // reserved locations flagged for zero data
  assign resv_hit = claim && (ofs >= 12'(IMPL_BYTES));
endmodule

/* File: logic/mrd_decoder.sv */
// Module register space decoder: claims internal accesses
`timescale 1ns/1ps
module mrd_decoder #(
  parameter int NUM_SLOT = mrd_pkg::MRD_NUM_SLOT
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic BUS_VALID,
  input wire logic [mrd_pkg::MRD_ADDR_W-1:0] BUS_ADDR,
  input wire logic BUS_WRITE,
  input wire logic BUS_SUPER,
  input wire logic [mrd_pkg::MRD_DATA_W-1:0] BUS_WDATA,
  input wire logic MODULE_MAP_BIT,
  input wire logic [NUM_SLOT-1:0] SUPERVISOR_ONLY_BIT,
  input wire logic [NUM_SLOT*mrd_pkg::MRD_DATA_W-1:0] MOD_RD_DATA,
  output logic [NUM_SLOT-1:0] MOD_SEL,
  output logic [mrd_pkg::MRD_NUM_ARR-1:0] ARRAY_SEL,
  output logic [mrd_pkg::MRD_NUM_ARR-1:0] ARRAY_EN,
  output logic INT_CLAIM,
  output logic EXT_ACCESS,
  output logic RD_VALID,
  output logic [mrd_pkg::MRD_DATA_W-1:0] RD_DATA
);
  import mrd_pkg::*;

  // Refuse more sub-blocks than the tables hold
  if (NUM_SLOT < 1 || NUM_SLOT > MRD_NUM_SLOT) begin : g_chk
    $error("mrd_decoder: NUM_SLOT out of range");
  end

  mrd_state_t st_reg; // Registered state
  mrd_state_t st_next; // Next state
  logic map_select_line; // Which half holds the block
  logic in_block; // Access inside the register block
  logic [NUM_SLOT-1:0] slot_claim; // Sub-block claims
  logic [NUM_SLOT-1:0] slot_resv; // Reserved location hits
  logic [MRD_NUM_ARR-1:0] ctrl_hit; // Array control block hits
  logic [MRD_NUM_ARR-1:0] arr_hit; // Array space hits
  logic reg_claim; // Claimed inside the register block
  logic [MRD_DATA_W-1:0] sel_data; // Read data before register

  // map bit drives the select line
  assign map_select_line = MODULE_MAP_BIT;

  // block sits at {map, 111, fixed bits}
  assign in_block = BUS_VALID &&
    (BUS_ADDR[23] == map_select_line) &&
    (BUS_ADDR[22:20] == MRD_BLK_TOP3) &&
    (BUS_ADDR[19:12] == MRD_BLK_MID);

  for (genvar i = 0; i < NUM_SLOT; i++) begin : g_slot
    mrd_slot #(
      .BASE(MRD_SLOT_BASE[i]),
      .SIZE_LOG2(MRD_SLOT_SIZE_LOG2[i]),
      .IMPL_BYTES(MRD_SLOT_IMPL[i]),
      .RESV_BYTES(MRD_SLOT_RESV[i])
    ) u_slot (
      .addr_lo(BUS_ADDR[11:0]),
      .in_block(in_block),
      .user_mode(!BUS_SUPER),
      .supervisor_only_bit_only(SUPERVISOR_ONLY_BIT[i]),
      .claim(slot_claim[i]),
      .resv_hit(slot_resv[i])
    );
  end

  // Array control blocks and array windows
  for (genvar a = 0; a < MRD_NUM_ARR; a++) begin : g_arr
    // 16-byte control block, all of it claimed
    assign ctrl_hit[a] = in_block &&
      (BUS_ADDR[11:4] == MRD_ARR_CTRL[a][11:4]);
    assign arr_hit[a] = BUS_VALID && !reg_claim && st_reg.arr_en[a] &&
      (BUS_ADDR[23:16] ==
       st_reg.arr_base[a*MRD_ARR_BASE_W +: MRD_ARR_BASE_W]);
  end

  assign reg_claim = (|slot_claim) || (|ctrl_hit);
  assign INT_CLAIM = reg_claim || (|arr_hit);
  assign EXT_ACCESS = BUS_VALID && !INT_CLAIM;
  assign MOD_SEL = slot_claim;
  assign ARRAY_SEL = arr_hit;
  assign ARRAY_EN = st_reg.arr_en;
  assign RD_VALID = st_reg.rd_valid;
  assign RD_DATA = st_reg.rd_data;

  // Read data mux and array control writes
  always_comb begin
    st_next = st_reg;
    sel_data = '0;
    // Sub-blocks never overlap, so at most one slot hits
    for (int i = 0; i < NUM_SLOT; i++) begin
      // reserved bits masked, reserved words zero
      if (slot_claim[i] && !slot_resv[i]) begin
        sel_data = MOD_RD_DATA[i*MRD_DATA_W +: MRD_DATA_W] &
          MRD_SLOT_MASK[i];
      end
    end
    for (int a = 0; a < MRD_NUM_ARR; a++) begin
      if (ctrl_hit[a]) begin
        // Control reads: unused bits read zero
        if (BUS_ADDR[3:0] == MRD_ARR_EN_OFS) begin
          sel_data = {15'h0000, st_reg.arr_en[a]};
        end else if (BUS_ADDR[3:0] == MRD_ARR_BASE_OFS) begin
          sel_data = {8'h00,
            st_reg.arr_base[a*MRD_ARR_BASE_W +: MRD_ARR_BASE_W]};
        end
        // master enables array and sets base
        if (BUS_WRITE && BUS_ADDR[3:0] == MRD_ARR_EN_OFS) begin
          st_next.arr_en[a] = BUS_WDATA[MRD_ARR_EN_BIT];
        end
        if (BUS_WRITE && BUS_ADDR[3:0] == MRD_ARR_BASE_OFS) begin
          st_next.arr_base[a*MRD_ARR_BASE_W +: MRD_ARR_BASE_W] =
            BUS_WDATA[MRD_ARR_BASE_W-1:0];
        end
      end
    end
    // Register block reads answer one cycle later from the register
    st_next.rd_valid = BUS_VALID && !BUS_WRITE && reg_claim;
    if (st_next.rd_valid) begin
      st_next.rd_data = sel_data;
    end
  end

  // State register, synchronous reset
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      st_reg <= MRD_STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Checks on the decode
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  // Access outside block and arrays must leave the chip
  AST_EXT_UNCLAIMED: assert property (
    BUS_VALID && !in_block && !(|ARRAY_SEL) |-> EXT_ACCESS)
    else $error("unclaimed access not sent external");

  // Register block hit only in the half chosen by the map bit
  AST_MAP_HALF: assert property (
    (|MOD_SEL) |-> BUS_ADDR[23] == MODULE_MAP_BIT)
    else $error("module hit in wrong half of memory");

  // Module hits carry the fixed bits A[22:20] and A[19:12]
  AST_TOP_NIBBLE: assert property (
    (|MOD_SEL) |-> BUS_ADDR[22:20] == MRD_BLK_TOP3 &&
      BUS_ADDR[19:12] == MRD_BLK_MID)
    else $error("module hit outside the register block");

  // At most one sub-block claims any access
  AST_ONE_SLOT: assert property (
    $onehot0(MOD_SEL))
    else $error("two sub-blocks claimed one access");

  // Module hit never reaches the external bus
  AST_INTERNAL: assert property (
    (|MOD_SEL) |-> INT_CLAIM && !EXT_ACCESS)
    else $error("module hit also sent external");

  // User access is never claimed by a protected module
  AST_SUPERVISOR_ONLY_BIT_EXT: assert property (
    BUS_VALID && !BUS_SUPER |-> !(|(MOD_SEL & SUPERVISOR_ONLY_BIT)))
    else $error("user access claimed by protected module");

  // Reserved location reads back as zero next cycle
  AST_RESV_ZERO: assert property (
    BUS_VALID && !BUS_WRITE && (|slot_resv)
    |=> RD_VALID && RD_DATA == 16'h0000)
    else $error("reserved location returned nonzero");

  // Last sub-block has a partial mask, so dropped bits show up
  AST_SLOT_READ: assert property (
    BUS_VALID && !BUS_WRITE && slot_claim[NUM_SLOT-1] &&
    !slot_resv[NUM_SLOT-1] |=> RD_VALID && RD_DATA ==
      ($past(MOD_RD_DATA[(NUM_SLOT-1)*MRD_DATA_W +: MRD_DATA_W]) &
       MRD_SLOT_MASK[NUM_SLOT-1]))
    else $error("module read data wrong");

  // Unused control words read back as zero next cycle
  AST_CTRL_ZERO: assert property (
    BUS_VALID && !BUS_WRITE && (|ctrl_hit) &&
    BUS_ADDR[3:0] != MRD_ARR_EN_OFS && BUS_ADDR[3:0] != MRD_ARR_BASE_OFS
    |=> RD_VALID && RD_DATA == 16'h0000)
    else $error("unused control word returned nonzero");

  // Hole in the register block goes external
  AST_HOLE_EXT: assert property (
    in_block && !reg_claim && !(|ARRAY_SEL) |-> EXT_ACCESS)
    else $error("unimplemented address claimed");

  // Disabled array 0 never selected; its enable write takes effect
  AST_ARR_OFF: assert property (
    !ARRAY_EN[0] |-> !ARRAY_SEL[0])
    else $error("disabled array selected");
  AST_ARR_ENABLE: assert property (
    BUS_WRITE && ctrl_hit[0] && BUS_ADDR[3:0] == MRD_ARR_EN_OFS &&
    BUS_WDATA[MRD_ARR_EN_BIT] |=> ARRAY_EN[0] ##1 1'b1)
    else $error("array enable write lost");

  // Main scenarios
  COV_EXT: cover property (EXT_ACCESS);
  COV_RESV: cover property (BUS_VALID && !BUS_WRITE && (|slot_resv));
  COV_SUPERVISOR_ONLY_BIT: cover property (BUS_VALID && !BUS_SUPER &&
    (|SUPERVISOR_ONLY_BIT) && in_block && EXT_ACCESS);
  COV_ARR: cover property (ARRAY_EN[0] ##[1:20] ARRAY_SEL[0]);
endmodule

/* File: verification/mrd_master.sv */
// Bus master model driving the internal module bus
`timescale 1ns/1ps
module mrd_master (
  input wire logic CLK,
  output logic BUS_VALID,
  output logic [23:0] BUS_ADDR,
  output logic BUS_WRITE,
  output logic BUS_SUPER,
  output logic [15:0] BUS_WDATA
);
  // Idle bus from time zero
  initial begin
    BUS_VALID = 1'b0;
    BUS_ADDR = 24'h000000;
    BUS_WRITE = 1'b0;
    BUS_SUPER = 1'b1;
    BUS_WDATA = 16'h0000;
  end
  // One access per cycle, launched just after the edge
  task automatic drive(input logic [23:0] a, input logic w, s,
                       input logic [15:0] d);
    @(posedge CLK);
    #1;
    BUS_VALID = 1'b1;
    BUS_ADDR = a;
    BUS_WRITE = w;
    BUS_SUPER = s;
    BUS_WDATA = d;
  endtask
  // Released bus flips its address and data lines so stale values never pass
  task automatic release_bus();
    @(posedge CLK);
    #1;
    BUS_VALID = 1'b0;
    BUS_ADDR = ~BUS_ADDR;
    BUS_WDATA = ~BUS_WDATA;
  endtask
endmodule

/* File: verification/mrd_decoder_tb.sv */
// Self-checking bench for the module register space decoder
`timescale 1ns/1ps
module mrd_decoder_tb;
  import mrd_pkg::*;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic BUS_VALID, BUS_WRITE, BUS_SUPER, INT_CLAIM, EXT_ACCESS, RD_VALID;
  logic [23:0] BUS_ADDR;
  logic [15:0] BUS_WDATA, RD_DATA;
  logic MODULE_MAP_BIT = 1'b0;
  logic [3:0] SUPERVISOR_ONLY_BIT = 4'h0;
  logic [63:0] MOD_RD_DATA = 64'h0;
  logic [3:0] MOD_SEL;
  logic [2:0] ARRAY_SEL, ARRAY_EN;
  int errors = 0;
  int comparisons = 0;
  // Route notes: claim, check-select, module select, array select
  logic [8:0] q_rt[$];
  logic [15:0] q_rd[$];
  always #2 CLK = ~CLK;
  mrd_master u_m (.CLK(CLK), .BUS_VALID(BUS_VALID), .BUS_ADDR(BUS_ADDR),
    .BUS_WRITE(BUS_WRITE), .BUS_SUPER(BUS_SUPER), .BUS_WDATA(BUS_WDATA));
  mrd_decoder u_dut (.CLK(CLK), .RST_B(RST_B), .BUS_VALID(BUS_VALID),
    .BUS_ADDR(BUS_ADDR), .BUS_WRITE(BUS_WRITE), .BUS_SUPER(BUS_SUPER),
    .BUS_WDATA(BUS_WDATA), .MODULE_MAP_BIT(MODULE_MAP_BIT),
    .SUPERVISOR_ONLY_BIT(SUPERVISOR_ONLY_BIT), .MOD_RD_DATA(MOD_RD_DATA),
    .MOD_SEL(MOD_SEL), .ARRAY_SEL(ARRAY_SEL), .ARRAY_EN(ARRAY_EN),
    .INT_CLAIM(INT_CLAIM), .EXT_ACCESS(EXT_ACCESS), .RD_VALID(RD_VALID),
    .RD_DATA(RD_DATA));
  task automatic cmp(input string n, input logic [15:0] e, s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Route kind of result: claim, external flag and selects
  task automatic cmp_rt(input logic [8:0] e);
    cmp("claim", {15'h0, e[8]}, {15'h0, INT_CLAIM});
    cmp("external", {15'h0, ~e[8]}, {15'h0, EXT_ACCESS});
    cmp("array_sel", {13'h0, e[2:0]}, {13'h0, ARRAY_SEL});
    if (e[7]) cmp("mod_sel", {12'h0, e[6:3]}, {12'h0, MOD_SEL});
  endtask
  // Monitor samples at the falling edge, where everything has settled
  always @(negedge CLK) begin
    if (RST_B === 1'b1 && BUS_VALID === 1'b1 && q_rt.size() > 0)
      cmp_rt(q_rt.pop_front());
    if (RST_B === 1'b1 && BUS_VALID === 1'b0)
      cmp("idle", 16'h0, {14'h0, INT_CLAIM, EXT_ACCESS});
    if (RD_VALID !== 1'b0) begin
      if (q_rd.size() > 0) cmp("rd_data", q_rd.pop_front(), RD_DATA);
      else cmp("rd_valid", 16'h0, {15'h0, RD_VALID});
    end
  end
  // One access; module data lands with the request, notes queued
  task automatic bus(input logic [23:0] a, input logic w, s,
    input logic [63:0] r, input logic [8:0] rt, input logic [16:0] rq);
    u_m.drive(a, w, s, r[15:0]);
    MOD_RD_DATA = r;
    q_rt.push_back(rt);
    if (rq[16]) q_rd.push_back(rq[15:0]);
  endtask
  function automatic logic [23:0] blk(input logic [11:0] o);
    return {MODULE_MAP_BIT, MRD_BLK_TOP3, MRD_BLK_MID, o};
  endfunction
  // Slot access: kind 0 implemented, 1 reserved, 2 hole
  task automatic slot(input int i, input logic [11:0] o, input int k,
                      input logic w, s);
    logic [63:0] r;
    logic cl;
    r = {$urandom, $urandom};
    cl = k < 2 && !(SUPERVISOR_ONLY_BIT[i] && !s);
    bus(blk(o), w, s, r, {cl, 1'b1, cl ? 4'h1 << i : 4'h0, 3'h0},
      {cl && !w, k == 0 ? r[16*i +: 16] & MRD_SLOT_MASK[i] : 16'h0});
  endtask
  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog keeps a hang from running forever
  initial begin
    repeat (20000) @(posedge CLK);
    errors++;
    $display("[FAIL] run expected end seen timeout");
    complete_run();
  end
  initial begin
    logic [11:0] b, e;
    void'($urandom(43));
    repeat (8) @(posedge CLK);
    #1 RST_B = 1'b1;
    cmp("array_en", 16'h0, {13'h0, ARRAY_EN});
    for (int m = 0; m < 2; m++) begin
      u_m.release_bus();
      MODULE_MAP_BIT = m[0];
      SUPERVISOR_ONLY_BIT = 4'h0;
      for (int i = 0; i < 4; i++) begin
        b = MRD_SLOT_BASE[i];
        e = 12'(MRD_SLOT_IMPL[i]);
        slot(i, b, 0, 1'b0, 1'b1);
        slot(i, b + e - 12'h2, 0, 1'b0, 1'b0);
        slot(i, b + e, 1, 1'b0, 1'b1);
        slot(i, b + e + 12'(MRD_SLOT_RESV[i]), 2, 1'b0, 1'b1);
        slot(i, b + 12'(1 << MRD_SLOT_SIZE_LOG2[i]) - 12'h2, 2, 1'b0,
             1'b1);
      end
      slot(0, 12'h800, 2, 1'b0, 1'b1);
      bus(blk(12'h002) ^ 24'h800000, 1'b0, 1'b1, 64'h0, 9'h0, 17'h0);
      $display("test map half %0d done", m);
    end
    for (int v = 0; v < 3; v++) begin
      u_m.release_bus();
      SUPERVISOR_ONLY_BIT = 4'($urandom);
      for (int i = 0; i < 4; i++)
        for (int k = 0; k < 4; k++)
          slot(i, MRD_SLOT_BASE[i], 0, k[0], k[1]);
    end
    $display("test supervisor done");
    for (int a = 0; a < 3; a++) begin
      b = 12'h010 + 12'(a);
      bus({b[7:0], 16'h0034}, 1'b0, 1'b1, 64'h0, 9'h0, 17'h0);
      bus(blk(MRD_ARR_CTRL[a]), 1'b1, 1'b1, 64'h1, 9'h180, 17'h0);
      bus(blk(MRD_ARR_CTRL[a]), 1'b0, 1'b1, 64'h0, 9'h180, 17'h10001);
      bus(blk(MRD_ARR_CTRL[a] + 12'h2), 1'b1, 1'b1, {56'h0, b[7:0]},
          9'h180, 17'h0);
      bus(blk(MRD_ARR_CTRL[a] + 12'h2), 1'b0, 1'b1, 64'h0, 9'h180,
          {9'h100, b[7:0]});
      bus(blk(MRD_ARR_CTRL[a] + 12'h4), 1'b0, 1'b1, 64'h0, 9'h180,
          17'h10000);
      bus({b[7:0], 16'h0034}, 1'b0, 1'b1, 64'h0, {6'h20, 3'(1 << a)},
          17'h0);
    end
    u_m.release_bus();
    cmp("array_en", 16'h7, {13'h0, ARRAY_EN});
    $display("test arrays done");
    RST_B = 1'b0;
    repeat (2) @(posedge CLK);
    #1 RST_B = 1'b1;
    cmp("array_en", 16'h0, {13'h0, ARRAY_EN});
    bus(24'h100034, 1'b0, 1'b1, 64'h0, 9'h0, 17'h0);
    u_m.release_bus();
    repeat (3) @(posedge CLK);
    cmp("pending", 16'h0, 16'(q_rt.size() + q_rd.size()));
    $display("test reset done");
    complete_run();
  end
endmodule
